// ==== logic/fpga_config_map.vh ====
`ifndef FPGA_CONFIG_MAP_VH
`define FPGA_CONFIG_MAP_VH

// ========================================
// Configuration modes on the mode straps
`define MODE_SLAVE_SERIAL  2'h0
`define MODE_MASTER_SERIAL 2'h1
`define MODE_MASTER_PAR    2'h2
`define MODE_PERIPHERAL    2'h3

// ========================================
// Widths and depths
`define BYTE_W      8
`define ADDR_W      16
`define FIFO_DEPTH  16
`define FIFO_AW     4
`define SYNC_W      16

// ========================================
// Timing
`define CLK_PERIOD_NS    10
`define HOLD_OFF_NS      1000
`define HOLD_OFF_CYCLES  ((`HOLD_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ========================================
// Reset values
`define ADDR_RESET  16'h0000

`endif

// ==== logic/fpga_config_pin_interface.v ====
`timescale 1ns/10ps
`include "fpga_config_map.vh"

// ========================================
// Byte FIFO between fetch and serializer
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW:0]      wr_ptr;
    reg  [AW:0]      rd_ptr;
    wire [AW:0]      fill;
    assign fill      = wr_ptr - rd_ptr;
    assign in_ready  = (fill != FULL_COUNT);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr[AW-1:0]];
    always @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule
// ========================================
// Configuration pin interface
// Operation
// - All four selects asserted means buffer write
// - Data latched when any select releases
// - Ready output paces peripheral host writes
// - Read pulse rises before address changes
// - Sixteen-bit EPROM address in master parallel
// - Parallel modes move one byte per transfer
// - Serial input is stream or bit 0
// - Cascade output forwards data to next slave
// - Pins become user I/O after configuration
// - Weak pull-ups active until configuration ends
// - Unused outputs tri-stated with pull-up
// - Hold-off line blocks master while low
// - Byte taken just before address steps
// - LSB on cascade 1.5 clocks after accept
module fpga_config_pin_interface (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire [1:0]  mode_strap,
    input  wire        config_clock,
    input  wire        config_done,
    input  wire        select_low_a,
    input  wire        select_low_b,
    input  wire        select_high,
    input  wire        write_strobe_low,
    input  wire [7:0]  parallel_byte_in,
    input  wire        hold_off_in,
    output reg         hold_off_out,
    output reg         hold_off_oe,
    output reg  [15:0] eprom_address_out,
    output reg         eprom_address_oe,
    output reg         read_pulse,
    output reg         read_pulse_oe,
    output reg         ready_busy,
    output reg         ready_busy_oe,
    output reg         cascade_out,
    output reg         cascade_oe,
    output reg         config_bit,
    output reg         config_bit_valid,
    output reg         pullup_enable,
    output reg         io_release
);
    localparam [1:0] ST_HOLD = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_LOAD = 2'h2;
    localparam [1:0] ST_DONE = 2'h3;
    localparam [1:0] SH_IDLE  = 2'h0;
    localparam [1:0] SH_ARM   = 2'h1;
    localparam [1:0] SH_SHIFT = 2'h2;
    localparam integer HOLD_CYCLES = `HOLD_OFF_CYCLES;
    // ========================================
    // Input synchronisers
    reg  [`SYNC_W-1:0] sync_a;
    reg  [`SYNC_W-1:0] sync_b;
    wire [`SYNC_W-1:0] pin_bundle;
    wire [1:0]         s_mode;
    wire               s_config_clock;
    wire               s_hold;
    wire [3:0]         s_sel;
    wire [7:0]         s_data;
    assign pin_bundle = {mode_strap, config_clock, hold_off_in, select_low_a, select_low_b,
                         select_high, write_strobe_low, parallel_byte_in};
    assign s_mode = sync_b[15:14];
    assign s_config_clock = sync_b[13];
    assign s_hold = sync_b[12];
    assign s_sel  = sync_b[11:8];
    assign s_data = sync_b[7:0];
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_a <= 16'h0000;
            sync_b <= 16'h0000;
        end else begin
            sync_a <= pin_bundle;
            sync_b <= sync_a;
        end
    end
    // Three selects low, one high; order a, b, high, strobe
    function write_on;
        input [3:0] sel;
        begin
            write_on = ~sel[3] & ~sel[2] & sel[1] & ~sel[0];
        end
    endfunction
    // ========================================
    // Edge detection and state
    reg        config_clock_prev;
    reg        wr_prev;
    reg [1:0]  state;
    reg [1:0]  mode;
    reg [15:0] hold_cnt;
    reg [1:0]  sh_state;
    reg [7:0]  sh_data;
    reg [2:0]  sh_cnt;
    reg        ser_bit;
    reg        push_valid;
    reg [7:0]  push_data;
    wire config_clock_rise = s_config_clock & ~config_clock_prev;
    wire config_clock_fall = ~s_config_clock & config_clock_prev;
    wire wr_now    = write_on(s_sel);
    wire loading   = (state == ST_LOAD);
    wire serial_md = (mode == `MODE_SLAVE_SERIAL) || (mode == `MODE_MASTER_SERIAL);
    wire is_master = (s_mode == `MODE_MASTER_SERIAL) || (s_mode == `MODE_MASTER_PAR);
    wire       fifo_in_ready;
    wire [7:0] fifo_out_data;
    wire       fifo_out_valid;
    wire       fifo_pop = loading & ~serial_md & (sh_state == SH_IDLE) & config_clock_rise;
    byte_fifo #(
        .WIDTH (`BYTE_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clk       (sys_clk),
        .rst       (rst),
        .in_data   (push_data),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );
    // ========================================
    // Sequencing
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state    <= ST_HOLD;
            mode     <= `MODE_SLAVE_SERIAL;
            hold_cnt <= 16'h0000;
        end else begin
            case (state)
                ST_HOLD: begin
                    hold_cnt <= hold_cnt + 16'h0001;
                    if (hold_cnt == HOLD_CYCLES[15:0] - 16'h0001) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!is_master || s_hold) begin
                        mode  <= s_mode;
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (config_done) begin
                        state <= ST_DONE;
                    end
                end
                default: begin
                    state <= ST_DONE;
                end
            endcase
        end
    end
    // ========================================
    // Byte fetch: peripheral writes, EPROM reads
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            config_clock_prev         <= 1'b0;
            wr_prev           <= 1'b0;
            push_valid        <= 1'b0;
            push_data         <= 8'h00;
            read_pulse        <= 1'b0;
            eprom_address_out <= `ADDR_RESET;
        end else begin
            config_clock_prev  <= s_config_clock;
            wr_prev    <= wr_now;
            push_valid <= 1'b0;
            read_pulse <= read_pulse & loading;
            if (loading && mode == `MODE_PERIPHERAL && wr_prev && !wr_now) begin
                push_data  <= s_data;
                push_valid <= 1'b1;
            end
            if (loading && mode == `MODE_MASTER_PAR && config_clock_rise && fifo_in_ready &&
                !push_valid && !read_pulse) begin
                push_data  <= s_data;
                push_valid <= 1'b1;
                read_pulse <= 1'b1;
            end
            if (read_pulse && config_clock_fall) begin
                read_pulse        <= 1'b0;
                eprom_address_out <= eprom_address_out + 16'h0001;
            end
        end
    end
    // ========================================
    // Serializer and cascade output
    // One idle clock period between bytes; a trade for a simpler shifter.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sh_state         <= SH_IDLE;
            sh_data          <= 8'h00;
            sh_cnt           <= 3'h0;
            ser_bit          <= 1'b0;
            cascade_out      <= 1'b1;
            config_bit       <= 1'b0;
            config_bit_valid <= 1'b0;
        end else begin
            config_bit_valid <= 1'b0;
            if (loading && serial_md) begin
                if (config_clock_rise) begin
                    ser_bit          <= s_data[0];
                    config_bit       <= s_data[0];
                    config_bit_valid <= 1'b1;
                end
                if (config_clock_fall) begin
                    cascade_out <= ser_bit;
                end
            end else if (loading) begin
                case (sh_state)
                    SH_IDLE: begin
                        if (fifo_pop && fifo_out_valid) begin
                            sh_data  <= fifo_out_data;
                            sh_cnt   <= 3'h0;
                            sh_state <= SH_ARM;
                        end
                    end
                    SH_ARM: begin
                        if (config_clock_fall) begin
                            sh_state <= SH_SHIFT;
                        end
                    end
                    SH_SHIFT: begin
                        if (config_clock_fall) begin
                            cascade_out      <= sh_data[0];
                            config_bit       <= sh_data[0];
                            config_bit_valid <= 1'b1;
                            sh_data          <= {1'b0, sh_data[7:1]};
                            sh_cnt           <= sh_cnt + 3'h1;
                            if (sh_cnt == 3'h7) begin
                                sh_state <= SH_IDLE;
                            end
                        end
                    end
                    default: begin
                        sh_state <= SH_IDLE;
                    end
                endcase
            end
        end
    end
    // ========================================
    // Pin roles and enables
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_off_out     <= 1'b0;
            hold_off_oe      <= 1'b0;
            eprom_address_oe <= 1'b0;
            read_pulse_oe    <= 1'b0;
            ready_busy       <= 1'b0;
            ready_busy_oe    <= 1'b0;
            cascade_oe       <= 1'b0;
            pullup_enable    <= 1'b1;
            io_release       <= 1'b0;
        end else begin
            hold_off_out <= 1'b0;
            hold_off_oe  <= (state == ST_HOLD);
            eprom_address_oe <= loading && mode == `MODE_MASTER_PAR;
            read_pulse_oe    <= loading && mode == `MODE_MASTER_PAR;
            ready_busy_oe    <= loading && mode == `MODE_PERIPHERAL;
            cascade_oe       <= loading;
            ready_busy <= loading && mode == `MODE_PERIPHERAL && !wr_now && !push_valid &&
                          !wr_prev && !fifo_out_valid && sh_state == SH_IDLE;
            pullup_enable <= (state != ST_DONE);
            io_release <= (state == ST_DONE);
        end
    end
endmodule

// ==== testbench/config_pin_checker_assertions.sv ====
`timescale 1ns/10ps
// ========
// Port checker
module config_pin_checker (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        hold_off_in,
    input wire logic        hold_off_out,
    input wire logic        hold_off_oe,
    input wire logic [15:0] eprom_address_out,
    input wire logic        eprom_address_oe,
    input wire logic        read_pulse,
    input wire logic        read_pulse_oe,
    input wire logic        ready_busy,
    input wire logic        ready_busy_oe,
    input wire logic        cascade_out,
    input wire logic        cascade_oe,
    input wire logic        config_bit,
    input wire logic        config_bit_valid,
    input wire logic        pullup_enable,
    input wire logic        io_release
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    addr_step_a: assert property (
        $changed(eprom_address_out) |-> eprom_address_out == $past(eprom_address_out) + 16'h0001)
        else $error("address did not step by one");
    addr_pulse_a: assert property (
        $changed(eprom_address_out) |-> $past(read_pulse) && !read_pulse)
        else $error("address moved without read pulse");
    pulse_oe_a: assert property (
        read_pulse |-> read_pulse_oe && eprom_address_oe && !ready_busy_oe)
        else $error("read pulse outside master parallel");
    hold_start_a: assert property (
        $rose(eprom_address_oe) |-> $past(hold_off_in, 2) && !hold_off_oe)
        else $error("master started while held off");
    hold_drive_a: assert property (
        hold_off_oe |-> !hold_off_out && !cascade_oe && !eprom_address_oe)
        else $error("hold-off phase drives wrongly");
    ready_idle_a: assert property (
        ready_busy_oe && ready_busy |-> !config_bit_valid)
        else $error("bits shifted while ready shown");
    cascade_bit_a: assert property (
        config_bit_valid && (ready_busy_oe || eprom_address_oe) |-> cascade_out == config_bit)
        else $error("cascade differs from shifted bit");
    bit_pulse_a: assert property (
        config_bit_valid |=> !config_bit_valid)
        else $error("bit valid longer than a cycle");
    user_release_a: assert property (
        io_release |-> !pullup_enable && !cascade_oe && !eprom_address_oe && !ready_busy_oe)
        else $error("config pins still driven after done");
    pullup_a: assert property (
        pullup_enable != io_release)
        else $error("pull-up state wrong");
endmodule

bind fpga_config_pin_interface config_pin_checker u_chk (
    .sys_clk(sys_clk), .rst(rst), .hold_off_in(hold_off_in), .hold_off_out(hold_off_out),
    .hold_off_oe(hold_off_oe), .eprom_address_out(eprom_address_out),
    .eprom_address_oe(eprom_address_oe), .read_pulse(read_pulse),
    .read_pulse_oe(read_pulse_oe), .ready_busy(ready_busy), .ready_busy_oe(ready_busy_oe),
    .cascade_out(cascade_out), .cascade_oe(cascade_oe), .config_bit(config_bit),
    .config_bit_valid(config_bit_valid), .pullup_enable(pullup_enable),
    .io_release(io_release)
);

// ==== testbench/eprom_model.sv ====
`timescale 1ns/10ps
// ========
// Byte-wide configuration store
module eprom_model (
    input  wire logic [15:0] addr,
    input  wire logic        oe,
    output logic      [7:0]  data
);
    logic [7:0] last = 8'h00;
    // one byte per address
    // Released bus shows inverse, never a stale byte
    always @(addr or oe) begin
        if (oe) begin
            last = addr[7:0] ^ 8'h3C;
        end
        data = oe ? last : ~last;
    end
endmodule

// ==== testbench/test_fpga_config_pin_interface.sv ====
`timescale 1ns/10ps
`include "fpga_config_map.vh"
module test_fpga_config_pin_interface;
    logic        sys_clk, rst, config_clock, config_done, config_clock_run, ext_hold;
    logic        select_low_a, select_low_b, select_high, write_strobe_low;
    logic [1:0]  mode_strap;
    logic [7:0]  host_data;
    wire  [7:0]  rom_data, parallel_byte_in;
    wire  [15:0] eprom_address_out;
    wire         hold_off_in, hold_off_out, hold_off_oe, eprom_address_oe, read_pulse;
    wire         read_pulse_oe, ready_busy, ready_busy_oe, cascade_out, cascade_oe;
    wire         config_bit, config_bit_valid, pullup_enable, io_release;
    int          failures = 0, num_checks = 0, cycles = 0;

    // ========
    // Wired-AND hold-off and shared data pins
    assign hold_off_in      = ext_hold & ~(hold_off_oe & ~hold_off_out);
    assign parallel_byte_in = eprom_address_oe ? rom_data : host_data;
    wire  [2:0]  role_oe = {eprom_address_oe, ready_busy_oe, cascade_oe};

    fpga_config_pin_interface DUT (
        .sys_clk(sys_clk), .rst(rst), .mode_strap(mode_strap), .config_clock(config_clock),
        .config_done(config_done), .select_low_a(select_low_a), .select_low_b(select_low_b),
        .select_high(select_high), .write_strobe_low(write_strobe_low),
        .parallel_byte_in(parallel_byte_in), .hold_off_in(hold_off_in),
        .hold_off_out(hold_off_out), .hold_off_oe(hold_off_oe),
        .eprom_address_out(eprom_address_out), .eprom_address_oe(eprom_address_oe),
        .read_pulse(read_pulse), .read_pulse_oe(read_pulse_oe), .ready_busy(ready_busy),
        .ready_busy_oe(ready_busy_oe), .cascade_out(cascade_out), .cascade_oe(cascade_oe),
        .config_bit(config_bit), .config_bit_valid(config_bit_valid),
        .pullup_enable(pullup_enable), .io_release(io_release));
    eprom_model rom (.addr(eprom_address_out), .oe(eprom_address_oe), .data(rom_data));

    // ========
    // Clocks and hang guard
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Link clock stands still between loads
    initial begin
        #6;
        forever begin
            #40;
            if (config_clock_run) config_clock = ~config_clock;
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    // ========
    // Shared tasks
    task automatic conclude();
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic collect(input int n, output logic [15:0] bits);
        int i, t;
        bits = 16'h0000;
        i = 0;
        t = 0;
        while (i < n && t < 2000) begin
            @(posedge sys_clk);
            #1;
            t++;
            if (config_bit_valid === 1'b1) begin
                bits[i] = config_bit;
                i++;
            end
        end
    endtask

    // ========
    // Scenarios
    task automatic start(input logic [1:0] m);
        logic [2:0] run;
        logic       held;
        held = (m == `MODE_MASTER_PAR) || (m == `MODE_MASTER_SERIAL);
        run = (m == `MODE_MASTER_PAR) ? 3'h5 : (m == `MODE_PERIPHERAL) ? 3'h3 : 3'h1;
        config_clock_run = 0;
        mode_strap = m;
        ext_hold = 0;
        rst = 1;
        tick(5);
        rst = 0;
        tick(2);
        check("hold_off_oe", hold_off_oe, 1);
        check("pullup_enable", pullup_enable, 1);
        check("cascade_oe", cascade_oe, 0);
        tick(150);
        check("load oe held", role_oe, held ? 3'h0 : run);
        ext_hold = 1;
        tick(6);
        check("load oe", role_oe, run);
        config_clock_run = 1;
    endtask
    task automatic host_write(input logic [7:0] b, input int k);
        logic [15:0] bits;
        int t;
        check("ready before", ready_busy, 1);
        {select_low_a, select_low_b, select_high, write_strobe_low} = 4'b0010;
        host_data = b;
        tick(6);
        check("busy on write", ready_busy, 0);
        // Only one select releases first
        case (k)
            0: write_strobe_low = 1;
            1: select_low_a = 1;
            2: select_low_b = 1;
            default: select_high = 0;
        endcase
        repeat (4) begin
            tick(1);
            check("busy held", ready_busy, 0);
        end
        host_data = ~b;
        {select_low_a, select_low_b, select_high, write_strobe_low} = 4'b1101;
        collect(8, bits);
        check("serial byte", bits[7:0], b);
        t = 0;
        while (ready_busy !== 1'b1 && t < 300) begin
            tick(1);
            t++;
        end
        check("ready after", ready_busy, 1);
    endtask
    task automatic master_fetch();
        logic [15:0] bits;
        collect(16, bits);
        check("eprom bytes", bits, 16'h3D3C);
        check("address moved", eprom_address_out > 16'h0001, 1);
    endtask
    task automatic finish_load();
        config_done = 1;
        tick(5);
        check("released", {io_release, pullup_enable, cascade_oe, read_pulse_oe}, 4'b1000);
        config_done = 0;
    endtask
    task automatic serial_stream(input logic [1:0] m, input logic [7:0] pat);
        logic [15:0] bits;
        start(m);
        fork
            for (int i = 0; i < 8; i++) begin
                @(negedge config_clock);
                host_data = {7'h00, pat[i]};
            end
            begin
                @(negedge config_clock);
                collect(8, bits);
            end
        join
        check("serial bits", bits[7:0], pat);
        @(negedge config_clock);
        tick(4);
        check("cascade last", cascade_out, pat[7]);
    endtask

    initial begin
        config_clock = 0;
        config_clock_run = 0;
        rst = 1;
        config_done = 0;
        ext_hold = 0;
        mode_strap = `MODE_PERIPHERAL;
        host_data = 8'h00;
        {select_low_a, select_low_b, select_high, write_strobe_low} = 4'b1101;
        tick(1);
        start(`MODE_PERIPHERAL);
        for (int k = 0; k < 4; k++) begin
            host_write(8'hA5 ^ 8'(k * 8'h33), k);
        end
        finish_load();
        start(`MODE_MASTER_PAR);
        master_fetch();
        finish_load();
        serial_stream(`MODE_MASTER_SERIAL, 8'h96);
        serial_stream(`MODE_SLAVE_SERIAL, 8'h4B);
        conclude();
    end
endmodule
